// ===== src/tsr_cnt_if.sv
// Link between register front end and the temperature counter
interface tsr_cnt_if;
	import tsr_pkg::*;
	logic run;
	logic mode;
	logic clear;
	tsr_div_t div;
	logic [1:0] sense;
	tsr_code_t code;
	logic valid;
	logic update;
	modport ctrl (output run, mode, clear, div, sense, input code, valid, update);
	modport cnt (input run, mode, clear, div, sense, output code, valid, update);
endinterface : tsr_cnt_if

// ===== src/tsr_counter.sv
// Gated pulse counter that turns the sensor output into an 11-bit code
`include "tsr_defines.svh"
module tsr_counter #(
	parameter int UPD_CYCLES = `TSR_UPD_TIME_NS / `TSR_CLK_PERIOD_NS
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control and result
	tsr_cnt_if.cnt c
);
	import tsr_pkg::*;

	localparam int BASE = UPD_CYCLES >> `TSR_DIV_REF;

	logic [`TSR_WIN_W-1:0] win_q;
	logic [`TSR_WIN_W-1:0] win_last;
	tsr_code_t acc_q;
	tsr_code_t code_q;
	logic valid_q;
	logic upd_q;
	logic prev_q;
	logic edge_seen;
	logic last;

	function automatic logic [`TSR_WIN_W-1:0] win_len(input tsr_div_t d);
		win_len = `TSR_WIN_W'(BASE) << d;
	endfunction : win_len

	assign win_last = win_len(c.div) - `TSR_WIN_W'(1);
	assign last = (win_q >= win_last);
	assign edge_seen = c.sense[c.mode] & ~prev_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= c.sense[c.mode];
		end
	end

	// Update period scales with divider code
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			win_q <= '0;
		end else if (c.clear) begin
			win_q <= '0;
		end else if (c.run) begin
			win_q <= last ? '0 : win_q + `TSR_WIN_W'(1);
		end
	end

	// Count rising edges of the selected sensor output, saturating
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			acc_q <= `TSR_CODE_RESET;
		end else if (c.clear) begin
			acc_q <= `TSR_CODE_RESET;
		end else if (c.run) begin
			if (last) begin
				acc_q <= `TSR_CODE_RESET;
			end else if (edge_seen && acc_q != `TSR_CODE_MAX) begin
				acc_q <= acc_q + 11'h001;
			end
		end
	end

	// Latch the code at window end; hold it while stopped
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			code_q <= `TSR_CODE_RESET;
			valid_q <= 1'b0;
			upd_q <= 1'b0;
		end else begin
			upd_q <= c.run && !c.clear && last;
			if (c.clear) begin
				valid_q <= 1'b0;
			end else if (c.run && last) begin
				code_q <= acc_q;
				valid_q <= 1'b1;
			end
		end
	end

	assign c.code = code_q;
	assign c.valid = valid_q;
	assign c.update = upd_q;

	property p_clear_zeroes;
		@(posedge clk_i) disable iff (rst_i)
		c.clear |=> (acc_q == `TSR_CODE_RESET) && (win_q == '0) && !valid_q;
	endproperty
	a_clear_zeroes: assert property (p_clear_zeroes) else $error("count not cleared");

	property p_window_end;
		@(posedge clk_i) disable iff (rst_i)
		(c.run && !c.clear && win_q == win_last) |=> upd_q && win_q == '0 && valid_q;
	endproperty
	a_window_end: assert property (p_window_end) else $error("window end missed");

	property p_no_early_update;
		@(posedge clk_i) disable iff (rst_i)
		(c.run && win_q < win_last) |=> !upd_q;
	endproperty
	a_no_early_update: assert property (p_no_early_update) else $error("early update");

	property p_hold_stopped;
		@(posedge clk_i) disable iff (rst_i)
		!c.run |=> $stable(code_q);
	endproperty
	a_hold_stopped: assert property (p_hold_stopped) else $error("code moved while stopped");
endmodule : tsr_counter

// ===== src/tsr_defines.svh
// Offsets, field positions, reset values and timing figures of the sensor readout
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

`define TSR_ADDR_UPPER 8'h4b
`define TSR_ADDR_LOWER 8'h4c
`define TSR_ADDR_CTRL 8'h4d

`define TSR_CTRL_RESET 8'h00
`define TSR_RDATA_RESET 8'h00
`define TSR_CODE_RESET 11'h000

`define TSR_MODE_BIT 7
`define TSR_EN_BIT 6
`define TSR_PD_BIT 5
`define TSR_CLR_BIT 4
`define TSR_DIV_HI 3
`define TSR_DIV_LO 1
`define TSR_SEL_BIT 0

`define TSR_VALID_BIT 7
`define TSR_UPPER_HI 2
`define TSR_CODE_HI 10
`define TSR_CODE_MID 8
`define TSR_CODE_LO_HI 7
`define TSR_CODE_MAX 11'h7ff

`define TSR_UPD_TIME_NS 66000
`define TSR_CLK_PERIOD_NS 8
`define TSR_DIV_REF 5
`define TSR_WIN_W 20

`endif

// ===== src/tsr_pkg.sv
// Types shared by the sensor readout modules
package tsr_pkg;
	typedef logic [10:0] tsr_code_t;
	typedef logic [2:0] tsr_div_t;
	typedef logic [7:0] tsr_byte_t;
endpackage : tsr_pkg

// ===== src/tsr_readout.sv
// Register front end of the die temperature readout
`include "tsr_defines.svh"
module tsr_readout #(
	parameter int UPD_CYCLES = `TSR_UPD_TIME_NS / `TSR_CLK_PERIOD_NS
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port from the serial configuration port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire tsr_pkg::tsr_byte_t reg_wdata_i,
	input wire logic reg_rd_i,
	output tsr_pkg::tsr_byte_t reg_rdata_o,
	output logic reg_rvalid_o,
	// Analog sensor outputs
	input wire logic proportional_pulse_i,
	input wire logic inverse_pulse_i,
	// Analog sensor control
	output logic sensor_pd_o,
	output logic sensor_mode_o,
	output logic sampler_sel_o
);
	import tsr_pkg::*;

	tsr_cnt_if cif ();

	tsr_byte_t ctrl_q;
	tsr_byte_t rdata_d;
	logic [1:0] pins;
	logic [1:0] sync1_q;
	logic [1:0] sync2_q;

	assign pins = {proportional_pulse_i, inverse_pulse_i};

	// Two-stage synchronisers on the sensor pins
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= pins[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	// Index 1 is the proportional source, 0 the inverse source
	assign cif.sense = sync2_q;

	// Control register write
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= `TSR_CTRL_RESET;
		end else if (reg_wr_i && reg_addr_i == `TSR_ADDR_CTRL) begin
			ctrl_q <= reg_wdata_i;
		end
	end

	assign cif.mode = ctrl_q[`TSR_MODE_BIT];
	assign cif.run = ctrl_q[`TSR_EN_BIT] && !ctrl_q[`TSR_PD_BIT];
	assign cif.clear = ctrl_q[`TSR_CLR_BIT];
	assign cif.div = ctrl_q[`TSR_DIV_HI:`TSR_DIV_LO];

	// Analog controls mirror the control register
	assign sensor_pd_o = ctrl_q[`TSR_PD_BIT];
	assign sensor_mode_o = ctrl_q[`TSR_MODE_BIT];
	assign sampler_sel_o = ctrl_q[`TSR_SEL_BIT];

	// Read decode
	always_comb begin
		rdata_d = `TSR_RDATA_RESET;
		unique case (reg_addr_i)
			`TSR_ADDR_UPPER: begin
				rdata_d[`TSR_UPPER_HI:0] = cif.code[`TSR_CODE_HI:`TSR_CODE_MID];
				rdata_d[`TSR_VALID_BIT] = cif.valid;
			end
			`TSR_ADDR_LOWER: begin
				rdata_d = cif.code[`TSR_CODE_LO_HI:0];
			end
			`TSR_ADDR_CTRL: begin
				rdata_d = ctrl_q;
			end
			default: begin
				rdata_d = `TSR_RDATA_RESET;
			end
		endcase
	end

	// Read answer, one cycle after the request
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= `TSR_RDATA_RESET;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= rdata_d;
			end
		end
	end

	tsr_counter #(
		.UPD_CYCLES(UPD_CYCLES)
	) u_counter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.c(cif.cnt)
	);

	property p_upper_code;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == `TSR_ADDR_UPPER)
			|=> reg_rvalid_o
			&& reg_rdata_o[`TSR_UPPER_HI:0] == $past(cif.code[`TSR_CODE_HI:`TSR_CODE_MID])
			&& reg_rdata_o[`TSR_VALID_BIT-1:`TSR_UPPER_HI+1] == '0;
	endproperty
	a_upper_code: assert property (p_upper_code) else $error("upper code wrong");

	property p_valid_flag;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == `TSR_ADDR_UPPER)
			|=> reg_rdata_o[`TSR_VALID_BIT] == $past(cif.valid);
	endproperty
	a_valid_flag: assert property (p_valid_flag) else $error("valid flag wrong");

	property p_valid_after_update;
		@(posedge clk_i) disable iff (rst_i)
		cif.update |-> cif.valid;
	endproperty
	a_valid_after_update: assert property (p_valid_after_update) else $error("no valid");

	property p_lower_code;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == `TSR_ADDR_LOWER)
			|=> reg_rvalid_o && reg_rdata_o == $past(cif.code[`TSR_CODE_LO_HI:0]);
	endproperty
	a_lower_code: assert property (p_lower_code) else $error("lower code wrong");

	property p_mode_select;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == `TSR_ADDR_CTRL)
			|=> cif.mode == $past(reg_wdata_i[`TSR_MODE_BIT])
			&& sensor_mode_o == cif.mode;
	endproperty
	a_mode_select: assert property (p_mode_select) else $error("mode not applied");

	property p_enable;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == `TSR_ADDR_CTRL && reg_wdata_i[`TSR_EN_BIT]
			&& !reg_wdata_i[`TSR_PD_BIT]) |=> cif.run;
	endproperty
	a_enable: assert property (p_enable) else $error("counter not enabled");

	property p_power_down;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == `TSR_ADDR_CTRL && reg_wdata_i[`TSR_PD_BIT])
			|=> !cif.run && sensor_pd_o ##1 !cif.update;
	endproperty
	a_power_down: assert property (p_power_down) else $error("power down ignored");

	property p_clear_count;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == `TSR_ADDR_CTRL && reg_wdata_i[`TSR_CLR_BIT])
			|=> cif.clear ##1 !cif.valid;
	endproperty
	a_clear_count: assert property (p_clear_count) else $error("clear ignored");

	property p_divider;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == `TSR_ADDR_CTRL)
			|=> cif.div == $past(reg_wdata_i[`TSR_DIV_HI:`TSR_DIV_LO]);
	endproperty
	a_divider: assert property (p_divider) else $error("divider not applied");

	property p_hold_code;
		@(posedge clk_i) disable iff (rst_i)
		(!cif.run && $stable(ctrl_q)) |=> $stable(cif.code) && $stable(cif.valid);
	endproperty
	a_hold_code: assert property (p_hold_code) else $error("code changed while off");

	property p_read_only;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i != `TSR_ADDR_CTRL) |=> $stable(ctrl_q);
	endproperty
	a_read_only: assert property (p_read_only) else $error("write leaked");

	property p_rvalid_pulse;
		@(posedge clk_i) disable iff (rst_i)
		reg_rvalid_o == $past(reg_rd_i);
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("rvalid wrong");

	property p_rdata_hold;
		@(posedge clk_i) disable iff (rst_i)
		!reg_rd_i |=> $stable(reg_rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

	property p_ctrl_readback;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == `TSR_ADDR_CTRL)
			|=> reg_rvalid_o && reg_rdata_o == $past(ctrl_q);
	endproperty
	a_ctrl_readback: assert property (p_ctrl_readback) else $error("readback wrong");
endmodule : tsr_readout

// ===== verif/tsr_readout_tb.sv
// Self-checking bench of the die temperature readout
`include "tsr_defines.svh"
module tsr_readout_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tsr_pkg::*;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic reg_wr_i = 1'b0;
	tsr_byte_t reg_wdata_i = 8'h00;
	logic reg_rd_i = 1'b0;
	tsr_byte_t reg_rdata_o;
	logic reg_rvalid_o;
	logic proportional_pulse_i = 1'b0;
	logic inverse_pulse_i = 1'b0;
	logic sensor_pd_o;
	logic sensor_mode_o;
	logic sampler_sel_o;
	int failures = 0;
	int n_compared = 0;
	int ph = 2;
	int ih = 5;
	tsr_byte_t up;
	tsr_byte_t lo;
	tsr_byte_t v;
	tsr_code_t code;

	tsr_readout #(.UPD_CYCLES(320)) DUT (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o),
		.proportional_pulse_i(proportional_pulse_i),
		.inverse_pulse_i(inverse_pulse_i),
		.sensor_pd_o(sensor_pd_o),
		.sensor_mode_o(sensor_mode_o),
		.sampler_sel_o(sampler_sel_o)
	);

	// Clock and sensor oscillators
	initial forever #4 clk_i = ~clk_i;
	initial forever begin
		repeat (ph) @(negedge clk_i);
		proportional_pulse_i = ~proportional_pulse_i;
	end
	initial forever begin
		repeat (ih) @(negedge clk_i);
		inverse_pulse_i = ~inverse_pulse_i;
	end

	task automatic complete_run();
		$display("Compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	task automatic chk_byte(string name, tsr_byte_t exp, tsr_byte_t seen);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk_byte

	task automatic chk_code(string name, int lo_b, int hi_b, tsr_code_t seen);
		n_compared++;
		if (^seen === 1'bx || int'(seen) < lo_b || int'(seen) > hi_b) begin
			failures++;
			$display("Error %s expected %0d to %0d seen %0d", name, lo_b, hi_b, seen);
		end
	endtask : chk_code

	task automatic wr(logic [7:0] a, tsr_byte_t d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask : wr

	task automatic rd(logic [7:0] a, output tsr_byte_t d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		chk_byte("rvalid", 8'h01, {7'h00, reg_rvalid_o});
		d = reg_rdata_o;
	endtask : rd

	// Window length and pulse period of the selected sensor
	function automatic int win(tsr_byte_t c);
		return 10 << c[3:1];
	endfunction : win
	function automatic int per(tsr_byte_t c);
		return c[7] ? 2 * ph : 2 * ih;
	endfunction : per

	task automatic meas(tsr_byte_t c);
		wr(`TSR_ADDR_CTRL, c);
		repeat (2 * win(c) + 20) @(negedge clk_i);
		wr(`TSR_ADDR_CTRL, 8'h20);
		rd(`TSR_ADDR_UPPER, up);
		rd(`TSR_ADDR_LOWER, lo);
		code = {up[2:0], lo};
		chk_byte("valid", 8'h80, up & 8'hf8);
		chk_code("code", win(c) / per(c) - 1, win(c) / per(c) + 1, code);
	endtask : meas

	task automatic hold(tsr_byte_t c, logic vld);
		wr(`TSR_ADDR_CTRL, c);
		repeat (400) @(negedge clk_i);
		rd(`TSR_ADDR_UPPER, up);
		rd(`TSR_ADDR_LOWER, lo);
		chk_byte("held upper", {vld, 4'h0, code[10:8]}, up);
		chk_byte("held lower", code[7:0], lo);
	endtask : hold

	// Hang guard, far beyond the expected run length
	initial begin
		#(8 * 40000);
		failures++;
		complete_run();
	end

	initial begin
		void'($urandom(32'hd3a6));
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd(8'h4b + i[7:0], v);
			chk_byte("reset read", 8'h00, v);
		end
		chk_byte("reset pins", 8'h00, {5'h00, sensor_pd_o, sensor_mode_o, sampler_sel_o});
		wr(`TSR_ADDR_UPPER, 8'hff);
		wr(`TSR_ADDR_LOWER, 8'hff);
		rd(`TSR_ADDR_UPPER, up);
		rd(`TSR_ADDR_LOWER, lo);
		chk_byte("read only", 8'h00, up | lo);
		repeat (6) begin
			v = tsr_byte_t'($urandom) & 8'hfe;
			wr(`TSR_ADDR_CTRL, v);
			chk_byte("pins", {5'h00, v[5], v[7], v[0]},
				{5'h00, sensor_pd_o, sensor_mode_o, sampler_sel_o});
			rd(`TSR_ADDR_CTRL, up);
			chk_byte("control", v, up);
		end
		meas(8'hca);
		for (int d = 0; d < 6; d++) begin
			ph = 2 + $urandom % 2;
			ih = ph + 3;
			meas({1'($urandom % 2), 3'b100, d[2:0], 1'b0});
		end
		hold(8'h20, 1'b1);
		hold(8'h0a, 1'b1);
		hold(8'hda, 1'b0);
		wr(`TSR_ADDR_CTRL, 8'h20);
		complete_run();
	end
endmodule : tsr_readout_tb
